// file: inc/psp_pkg.sv
// package: register map, sram layout and field positions for the parameter sram port
package psp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] REG_TARGET_ALIAS = 8'h06;
    localparam logic [7:0] REG_CM_ALIAS = 8'h0C;
    localparam logic [7:0] REG_SRAM_POINTER = 8'h2B;
    localparam logic [7:0] REG_SRAM_DATA = 8'h2C;
    localparam logic [7:0] LOC_MAX_OUT = 8'h20;
    localparam logic [7:0] LOC_MIN_OUT = 8'h21;
    localparam logic [7:0] LOC_TARGET = 8'h22;
    localparam logic [7:0] LOC_KP = 8'h23;
    localparam logic [7:0] LOC_FAULT_CMP = 8'h24;
    localparam logic [7:0] LOC_CM = 8'h25;
    localparam logic [7:0] LOC_KI = 8'h26;
    localparam logic [7:0] LOC_LOOP_CFG = 8'h27;
    localparam int POL_BIT = 0;
    localparam int ADC_MODE_BIT = 1;
    localparam int TARGET_HI = 9;
    localparam int TARGET_LO = 0;
    localparam int CM_HI = 11;
    localparam int CM_LO = 2;
    localparam int LEVEL_HI = 15;
    localparam int LEVEL_LO = 6;
    localparam logic [15:0] TARGET_MASK = 16'h03FF;
    localparam logic [15:0] CM_MASK = 16'h0FFC;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // register access request from the host target interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } psp_req_t;

    // controller parameters decoded from the sram
    typedef struct packed {
        logic [9:0] target_value;
        logic [15:0] kp;
        logic [15:0] ki;
        logic [9:0] max_out;
        logic [9:0] min_out;
        logic [9:0] common_mode;
        logic loop_no_invert;
        logic first_converter_input_hiz;
        logic [9:0] fallback_level;
        logic [9:0] fault_compare_level;
    } psp_params_t;

    typedef struct packed {
        logic [7:0] pointer;
        logic [15:0] rdata;
        logic rvalid;
        logic force_fallback;
    } psp_state_t;
endpackage

// file: verilog/psp_sram_port.sv
// parameter sram with indirect pointer/data register access and parameter decode
//
// Summary of operation
// - 8-bit pointer in address register bits 7-0 selects next sram location.
// - every data-register write advances the pointer by one.
// - 16-bit data register writes and reads the word at the pointer.
// - address register decoded at 2Bh, resets to zero.
// - target value at sram 0x22[9:0], aliased at register 0x06[9:0].
// - proportional gain is all of sram 0x23.
// - integral gain is all of sram 0x26.
// - upper clamp sram 0x20[15:6], lower clamp sram 0x21[15:6].
// - common mode at sram 0x25[11:2], aliased at register 0x0C[11:2].
// - loop polarity is sram 0x27 bit 0.
// - converter input mode is sram 0x27 bit 1.
// - fallback level is sram 0x27[15:6].
// - fault compare level is sram 0x24[15:6].
// - polarity 1 means no inversion in the internal loop.
// - mode bit 0 puts the first converter input in high impedance.
// - low comparator output forces the controller to its fallback state.
`timescale 1ns/10ps
module psp_sram_port (
    input wire logic clock,
    input wire logic rstn,
    input wire psp_pkg::psp_req_t req,
    input wire logic fault_cmp_async,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic [7:0] sram_pointer,
    output logic force_fallback,
    output psp_pkg::psp_params_t params
);

////////////////////////////////////////////////////////////////////////
    logic [15:0] mem [0:255];
    psp_pkg::psp_state_t st_reg;
    psp_pkg::psp_state_t st_next;
    psp_pkg::psp_params_t par_reg;
    psp_pkg::psp_params_t par_next;
    logic cmp_meta_reg;
    logic cmp_sync_reg;
    logic [15:0] rd_word;
    logic data_wr;
    logic data_rd;
    logic hit_mem;

////////////////////////////////////////////////////////////////////////
    // comparator pin is asynchronous: two-flop synchroniser
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmp_meta_reg <= 1'b1;
            cmp_sync_reg <= 1'b1;
        end else begin
            cmp_meta_reg <= fault_cmp_async;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    assign data_wr = req.wr && req.addr == psp_pkg::REG_SRAM_DATA;
    assign data_rd = req.rd && req.addr == psp_pkg::REG_SRAM_DATA;

    // sram storage; contents are not reset, like a real sram, parameters are
    // mirrored into resettable flops below so outputs are zero during reset
    always_ff @(posedge clock) begin
        if (data_wr) begin
            mem[st_reg.pointer] <= req.wdata;
        end
        // alias write lands in sram target field
        if (req.wr && req.addr == psp_pkg::REG_TARGET_ALIAS) begin
            mem[psp_pkg::LOC_TARGET] <= req.wdata & psp_pkg::TARGET_MASK;
        end
        // alias write lands in sram common-mode field
        if (req.wr && req.addr == psp_pkg::REG_CM_ALIAS) begin
            mem[psp_pkg::LOC_CM] <= req.wdata & psp_pkg::CM_MASK;
        end
    end

    // read mux: written-this-cycle data not forwarded; reads see stored word
    always_comb begin
        rd_word = mem[st_reg.pointer];
        hit_mem = 1'b1;
        case (req.addr)
            psp_pkg::REG_SRAM_POINTER: begin
                rd_word = 16'(st_reg.pointer);
            end
            psp_pkg::REG_SRAM_DATA: begin
                rd_word = mem[st_reg.pointer];
            end
            psp_pkg::REG_TARGET_ALIAS: begin
                rd_word = mem[psp_pkg::LOC_TARGET] & psp_pkg::TARGET_MASK;
            end
            psp_pkg::REG_CM_ALIAS: begin
                rd_word = mem[psp_pkg::LOC_CM] & psp_pkg::CM_MASK;
            end
            default: begin
                rd_word = 16'h0000;
                hit_mem = 1'b0;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = req.rd;
        if (req.rd) begin
            st_next.rdata = hit_mem ? rd_word : 16'h0000;
        end
        if (req.wr && req.addr == psp_pkg::REG_SRAM_POINTER) begin
            st_next.pointer = req.wdata[7:0];
        end else if (data_wr) begin
            // advance after write, wraps at 255
            st_next.pointer = st_reg.pointer + psp_pkg::PTR_STEP;
        end
        // data reads do not touch the pointer
        if (data_rd) begin
            st_next.rdata = rd_word;
        end
        st_next.force_fallback = !cmp_sync_reg;
    end

    always_comb begin
        par_next = par_reg;
        par_next.target_value = mem[psp_pkg::LOC_TARGET][psp_pkg::TARGET_HI:psp_pkg::TARGET_LO];
        par_next.kp = mem[psp_pkg::LOC_KP];
        par_next.ki = mem[psp_pkg::LOC_KI];
        par_next.max_out = mem[psp_pkg::LOC_MAX_OUT][psp_pkg::LEVEL_HI:psp_pkg::LEVEL_LO];
        par_next.min_out = mem[psp_pkg::LOC_MIN_OUT][psp_pkg::LEVEL_HI:psp_pkg::LEVEL_LO];
        par_next.common_mode = mem[psp_pkg::LOC_CM][psp_pkg::CM_HI:psp_pkg::CM_LO];
        par_next.loop_no_invert = mem[psp_pkg::LOC_LOOP_CFG][psp_pkg::POL_BIT];
        // mode 0 = high impedance input
        par_next.first_converter_input_hiz = !mem[psp_pkg::LOC_LOOP_CFG][psp_pkg::ADC_MODE_BIT];
        par_next.fallback_level = mem[psp_pkg::LOC_LOOP_CFG][psp_pkg::LEVEL_HI:psp_pkg::LEVEL_LO];
        par_next.fault_compare_level = mem[psp_pkg::LOC_FAULT_CMP][psp_pkg::LEVEL_HI:psp_pkg::LEVEL_LO];
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.pointer <= psp_pkg::POINTER_RESET[7:0];
            st_reg.rdata <= psp_pkg::DATA_RESET;
            par_reg <= '0;
        end else begin
            st_reg <= st_next;
            par_reg <= par_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign rvalid = st_reg.rvalid;
    assign sram_pointer = st_reg.pointer;
    assign force_fallback = st_reg.force_fallback;
    assign params = par_reg;
endmodule

// file: sim/psp_host.sv
// host model issuing register requests to the sram port
`timescale 1ns/10ps
module psp_host (
    input wire logic clock,
    input wire logic rvalid,
    input wire logic [15:0] rdata,
    output psp_pkg::psp_req_t req
);
    initial req = '0;
    task automatic put(input logic w, input logic [7:0] a, input logic [15:0] x);
        @(posedge clock);
        req <= '{w, !w, a, x};
        @(posedge clock);
        // released data lines carry junk, never the old word
        req <= '{1'b0, 1'b0, a, ~x};
    endtask
    task automatic get(input logic [7:0] a, output logic [15:0] x, output logic v);
        put(1'b0, a, 16'h0000);
        #1;
        v = rvalid;
        x = rdata;
    endtask
endmodule

// file: sim/psp_sram_port_sva.sv
// checker for the parameter sram port
`timescale 1ns/10ps
module psp_sram_port_sva (
    input wire logic clock,
    input wire logic rstn,
    input wire psp_pkg::psp_req_t req,
    input wire logic fault_cmp_async,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic [7:0] sram_pointer,
    input wire logic force_fallback,
    input wire psp_pkg::psp_params_t params
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic dw;
    assign dw = req.wr && req.addr == 8'h2C;
    a_read_answer: assert property (req.rd |=> rvalid) else $error("no read answer");
    a_ptr_load: assert property (req.wr && req.addr == 8'h2B |=> sram_pointer == $past(req.wdata[7:0]))
        else $error("pointer load");
    a_ptr_advance: assert property (dw |=> sram_pointer == $past(sram_pointer) + 8'h01) else $error("no advance");
    a_read_hold: assert property (req.rd |=> $stable(sram_pointer)) else $error("read moved pointer");
    a_target_mirror: assert property (dw && sram_pointer == 8'h22 |-> ##2 params.target_value == $past(req.wdata[9:0], 2))
        else $error("target field");
    a_gain_mirror: assert property (dw && sram_pointer == 8'h23 |-> ##2 params.kp == $past(req.wdata, 2))
        else $error("gain field");
    a_fault_forces: assert property (!fault_cmp_async [*4] |=> force_fallback) else $error("no fallback");
    a_fault_clears: assert property (fault_cmp_async [*4] |=> !force_fallback) else $error("stuck fallback");
    c_data_write: cover property (dw);
    c_read: cover property (req.rd);
    c_fault: cover property ($rose(force_fallback));
endmodule
bind psp_sram_port psp_sram_port_sva u_sva (.*);

// file: sim/tb_top.sv
// bench for the parameter sram port
`timescale 1ns/10ps
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic fault_cmp_async = 1'b1;
    logic rvalid, force_fallback, v;
    logic [7:0] sram_pointer;
    logic [15:0] rdata, d;
    logic [15:0] w [8] = '{16'hFFC0, 16'h0000, 16'h0256, 16'h0FA0, 16'h7FC0, 16'h7FC0, 16'h0001, 16'hABC1};
    psp_pkg::psp_req_t req;
    psp_pkg::psp_params_t params;
    int bad_count = 0;
    int cmp_count = 0;
    psp_sram_port dut (.*);
    psp_host host (.*);
    initial forever #50 clock = ~clock;
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_fill();
        // upper pointer bits must be ignored
        host.put(1'b1, 8'h2B, 16'hA520);
        for (int i = 0; i < 8; i++) host.put(1'b1, 8'h2C, w[i]);
        repeat (2) @(posedge clock);
        #1;
        chk("ptr", sram_pointer, 16'h0028);
        chk("max", params.max_out, 16'h03FF);
        chk("min", params.min_out, 16'h0000);
        chk("tgt", params.target_value, 16'h0256);
        chk("kp", params.kp, 16'h0FA0);
        chk("cmp", params.fault_compare_level, 16'h01FF);
        chk("cm", params.common_mode, 16'h03F0);
        chk("ki", params.ki, 16'h0001);
        chk("pol", params.loop_no_invert, 16'h0001);
        chk("hiz", params.first_converter_input_hiz, 16'h0001);
        chk("fix", params.fallback_level, 16'h02AF);
    endtask
    task automatic t_read();
        host.put(1'b1, 8'h2B, 16'h0023);
        repeat (2) begin
            host.get(8'h2C, d, v);
            chk("rv", v, 16'h0001);
            chk("rd", d, 16'h0FA0);
        end
        chk("ptr", sram_pointer, 16'h0023);
        host.get(8'h2B, d, v);
        chk("pr", d, 16'h0023);
        host.get(8'h50, d, v);
        chk("gap", d, 16'h0000);
    endtask
    task automatic t_alias();
        host.put(1'b1, 8'h06, 16'h0155);
        host.put(1'b1, 8'h0C, 16'h0AAC);
        repeat (2) @(posedge clock);
        #1;
        chk("tgt", params.target_value, 16'h0155);
        chk("cm", params.common_mode, 16'h02AB);
        // pointer wraps at the top of the sram
        host.put(1'b1, 8'h2B, 16'h00FF);
        host.put(1'b1, 8'h2C, 16'h1234);
        #1;
        chk("wrap", sram_pointer, 16'h0000);
        // inverted polarity and buffered converter input
        host.put(1'b1, 8'h2B, 16'h0027);
        host.put(1'b1, 8'h2C, 16'h0002);
        repeat (2) @(posedge clock);
        #1;
        chk("pol0", params.loop_no_invert, 16'h0000);
        chk("hiz0", params.first_converter_input_hiz, 16'h0000);
    endtask
    task automatic t_fault();
        @(posedge clock);
        fault_cmp_async <= 1'b0;
        for (int i = 0; i < 8 && force_fallback !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("ff", force_fallback, 16'h0001);
        if (force_fallback !== 1'b1) complete_run();
        @(posedge clock);
        fault_cmp_async <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        chk("ffc", force_fallback, 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chk("rst", sram_pointer, 16'h0000);
        t_fill();
        t_read();
        t_alias();
        t_fault();
        complete_run();
    end
endmodule
